//--- src/cudc_pkg.sv
// Constants and types for the configurable up/down counter
package cudc_pkg;

   // ***************************************************
   // Modes
   // ***************************************************
   typedef enum logic
   {
      CUDC_EDGE_RISE = 1'b0,
      CUDC_EDGE_FALL = 1'b1
   } cudc_edge_t;

   typedef enum logic
   {
      CUDC_LOAD_SYNC  = 1'b0,
      CUDC_LOAD_ASYNC = 1'b1
   } cudc_load_t;

   // Pin group, carried through the synchroniser as one word
   typedef struct packed
   {
      logic clk;
      logic up;
      logic enable;
      logic preset;
      logic clear;
   } cudc_pins_t;

   // ***************************************************
   // Register map
   // ***************************************************
   localparam int          CUDC_ADDR_W       = 12;
   localparam logic [11:0] CUDC_CTRL_OFFSET  = 12'h000;
   localparam logic [11:0] CUDC_COUNT_OFFSET = 12'h004;
   localparam int          CUDC_CTRL_HOLD    = 0;
   localparam logic        CUDC_HOLD_RESET   = 1'h0;
   localparam logic [4:0]  CUDC_PINS_RESET   = 5'h00;

   // Load value that switches a load input off
   localparam int          CUDC_IGNORE_VALUE = -1;

endpackage

//--- src/cudc_counter.sv
// Up/down counter with pin controls and an APB view of its state
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module cudc_counter
   import cudc_pkg::*;
#(
   parameter int         COUNTER_WIDTH      = 8,
   parameter cudc_edge_t CLOCK_EDGE_SELECT  = CUDC_EDGE_RISE,
   parameter int         POWER_UP_VALUE     = 0,
   parameter int         CLEAR_LOAD_VALUE   = 0,
   parameter int         PRESET_LOAD_VALUE  = 0,
   parameter logic       PRESET_CLEAR_LEVEL = 1'b1,
   parameter cudc_load_t LOAD_TIMING        = CUDC_LOAD_SYNC
)
(
   input  wire logic                     clock,
   input  wire logic                     rst,
   input  wire logic                     counter_clk,
   input  wire logic                     count_up,
   input  wire logic                     count_enable,
   input  wire logic                     preset_in,
   input  wire logic                     clear_in,
   output var  logic [COUNTER_WIDTH-1:0] count_out,
   output var  logic                     count_oe,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [CUDC_ADDR_W-1:0]   paddr,
   input  wire logic [31:0]              pwdata,
   output var  logic [31:0]              prdata,
   output var  logic                     pready,
   output var  logic                     pslverr
);

   // ***************************************************
   // Build-time constants
   // ***************************************************
   localparam logic CLEAR_EN  = (CLEAR_LOAD_VALUE != CUDC_IGNORE_VALUE);
   localparam logic PRESET_EN = (PRESET_LOAD_VALUE != CUDC_IGNORE_VALUE);
   localparam logic [COUNTER_WIDTH-1:0] CLEAR_VAL  =
      COUNTER_WIDTH'(CLEAR_LOAD_VALUE);
   localparam logic [COUNTER_WIDTH-1:0] PRESET_VAL =
      COUNTER_WIDTH'(PRESET_LOAD_VALUE);
   localparam logic [COUNTER_WIDTH-1:0] POWER_VAL  =
      COUNTER_WIDTH'(POWER_UP_VALUE);
   localparam logic [COUNTER_WIDTH-1:0] ONE_VAL    =
      COUNTER_WIDTH'(1);

   // Loads reset to their idle level: active-low pins would
   // otherwise fire a load in the first cycles after reset
   localparam cudc_pins_t PINS_IDLE =
      CUDC_PINS_RESET | {3'b000, {2{~PRESET_CLEAR_LEVEL}}};

   // ***************************************************
   // Pin synchroniser and edge detect
   // ***************************************************
   cudc_pins_t pins_raw;
   cudc_pins_t sync1_r;
   cudc_pins_t sync2_r;
   logic       prev_clk_r;
   logic       edge_seen;
   logic       clear_act;
   logic       preset_act;

   assign pins_raw = '{clk: counter_clk, up: count_up,
                       enable: count_enable, preset: preset_in,
                       clear: clear_in};

   // Pins come from another timing world; only sync2 is read
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         sync1_r    <= PINS_IDLE;
         sync2_r    <= PINS_IDLE;
         prev_clk_r <= 1'b0;
      end
      else
      begin
         sync1_r    <= pins_raw;
         sync2_r    <= sync1_r;
         prev_clk_r <= sync2_r.clk;
      end
   end

   always_comb
   begin
      if (CLOCK_EDGE_SELECT == CUDC_EDGE_RISE)
         edge_seen = sync2_r.clk & ~prev_clk_r;
      else
         edge_seen = ~sync2_r.clk & prev_clk_r;
   end

   assign clear_act  = (sync2_r.clear == PRESET_CLEAR_LEVEL);
   assign preset_act = (sync2_r.preset == PRESET_CLEAR_LEVEL);

   // ***************************************************
   // Counter core
   // ***************************************************
   logic [COUNTER_WIDTH-1:0] count_r;
   logic [COUNTER_WIDTH-1:0] count_nxt;
   logic [COUNTER_WIDTH-1:0] count_out_nxt;
   logic                     count_oe_nxt;
   logic                     hold_r;
   logic                     hold_nxt;
   logic                     load_ok;
   logic                     clr_hit;
   logic                     pre_hit;

   // Async loads still pass the synchroniser: two cycles of latency
   assign load_ok = (LOAD_TIMING == CUDC_LOAD_ASYNC) | edge_seen;
   assign clr_hit = CLEAR_EN & clear_act;
   assign pre_hit = PRESET_EN & preset_act;

   always_comb
   begin
      count_nxt = count_r;
      if (load_ok && clr_hit)
         count_nxt = CLEAR_VAL;
      else if (load_ok && pre_hit)
         count_nxt = PRESET_VAL;
      else if (edge_seen && !hold_r)
      begin
         if (sync2_r.up)
            count_nxt = count_r + ONE_VAL;
         else
            count_nxt = count_r - ONE_VAL;
      end
      count_oe_nxt  = sync2_r.enable;
      count_out_nxt = sync2_r.enable ? count_r : '0;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         count_r   <= POWER_VAL;
         count_out <= '0;
         count_oe  <= 1'b0;
      end
      else
      begin
         count_r   <= count_nxt;
         count_out <= count_out_nxt;
         count_oe  <= count_oe_nxt;
      end
   end

   // ***************************************************
   // APB slave
   // ***************************************************
   logic        access;
   logic        ready_nxt;
   logic        err_nxt;
   logic [31:0] rdata_nxt;
   logic        addr_ok;

   assign access  = psel & penable;
   assign addr_ok = (paddr == CUDC_CTRL_OFFSET) |
                    (paddr == CUDC_COUNT_OFFSET);

   // One wait state keeps prdata a plain flop output
   always_comb
   begin
      ready_nxt = access & ~pready;
      err_nxt   = access & ~pready & ~addr_ok;
      rdata_nxt = prdata;
      hold_nxt  = hold_r;
      if (access && !pready && !pwrite)
      begin
         if (paddr == CUDC_CTRL_OFFSET)
            rdata_nxt = {31'h0, hold_r};
         else if (paddr == CUDC_COUNT_OFFSET)
            rdata_nxt = 32'(count_r);
         else
            rdata_nxt = 32'h0;
      end
      if (access && pready && pwrite && paddr == CUDC_CTRL_OFFSET)
         hold_nxt = pwdata[CUDC_CTRL_HOLD];
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
         hold_r  <= CUDC_HOLD_RESET;
      end
      else
      begin
         pready  <= ready_nxt;
         pslverr <= err_nxt;
         prdata  <= rdata_nxt;
         hold_r  <= hold_nxt;
      end
   end

   // ***************************************************
   // Checks
   // ***************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   edge_only_a: assert property (
      !edge_seen && !(LOAD_TIMING == CUDC_LOAD_ASYNC && (clr_hit || pre_hit))
      |=> $stable(count_r))
      else $error("count moved without a selected edge");

   clear_load_a: assert property (
      sync2_r.clear == PRESET_CLEAR_LEVEL && CLEAR_EN && load_ok
      |=> count_r == CLEAR_VAL)
      else $error("clear did not load its value");

   preset_load_a: assert property (
      sync2_r.preset == PRESET_CLEAR_LEVEL && PRESET_EN && !clr_hit
      && load_ok |=> count_r == PRESET_VAL)
      else $error("preset did not load its value");

   idle_level_a: assert property (
      sync2_r.clear != PRESET_CLEAR_LEVEL
      && sync2_r.preset != PRESET_CLEAR_LEVEL && edge_seen && !hold_r
      && sync2_r.up |=> count_r == $past(count_r) + ONE_VAL)
      else $error("inactive load level disturbed counting");

   async_load_a: assert property (
      LOAD_TIMING == CUDC_LOAD_ASYNC && clr_hit && !edge_seen
      |=> count_r == CLEAR_VAL)
      else $error("async clear waited for a clock edge");

   up_wrap_a: assert property (
      edge_seen && !clr_hit && !pre_hit && !hold_r && sync2_r.up
      && count_r == '1 |=> count_r == '0)
      else $error("up count did not wrap at the top of the width");

   power_up_a: assert property (
      $past(rst) |-> count_r == POWER_VAL && !count_oe)
      else $error("counter did not start at power-up value");

   out_disable_a: assert property (
      !sync2_r.enable |=> !count_oe && count_out == '0)
      else $error("output driven while enable inactive");

   out_follow_a: assert property (
      sync2_r.enable |=> count_oe && count_out == $past(count_r))
      else $error("enabled output does not show count");

   down_wrap_a: assert property (
      edge_seen && !clr_hit && !pre_hit && !hold_r && !sync2_r.up
      && count_r == '0 |=> count_r == '1)
      else $error("down count did not wrap");

   down_step_a: assert property (
      edge_seen && !clr_hit && !pre_hit && !hold_r && !sync2_r.up
      |=> count_r == $past(count_r) - ONE_VAL)
      else $error("down count did not step by one");

   clear_wins_a: assert property (
      load_ok && clr_hit && pre_hit
      |=> count_r == CLEAR_VAL)
      else $error("preset beat a pending clear");

   preset_off_a: assert property (
      !PRESET_EN && sync2_r.preset == PRESET_CLEAR_LEVEL && edge_seen
      && !clr_hit && !hold_r && !sync2_r.up
      |=> count_r == $past(count_r) - ONE_VAL)
      else $error("disabled preset disturbed counting");

   sync_wait_a: assert property (
      LOAD_TIMING == CUDC_LOAD_SYNC && (clr_hit || pre_hit) && !edge_seen
      |=> $stable(count_r))
      else $error("sync load acted between clock edges");

   hold_freeze_a: assert property (
      edge_seen && hold_r && !clr_hit && !pre_hit |=> $stable(count_r))
      else $error("frozen count moved on a clock edge");

   // ***************************************************
   // Register bus checks
   // ***************************************************
   apb_ready_a: assert property (
      access && !pready |=> pready ##1 !pready)
      else $error("apb answer not one cycle wide");

   apb_error_a: assert property (
      access && !pready && !addr_ok |=> pready && pslverr)
      else $error("unmapped access did not signal an error");

   err_with_ready_a: assert property (
      pslverr |-> pready)
      else $error("error flag without a bus answer");

   hold_write_a: assert property (
      access && pready && pwrite && paddr == CUDC_CTRL_OFFSET
      && pwdata[CUDC_CTRL_HOLD] |=> hold_r)
      else $error("control write did not set the hold bit");

   hold_clear_a: assert property (
      access && pready && pwrite && paddr == CUDC_CTRL_OFFSET
      && !pwdata[CUDC_CTRL_HOLD] |=> !hold_r)
      else $error("control write did not clear the hold bit");

endmodule

`default_nettype wire

//--- test/cudc_pin_model.sv
// Surrounding logic that drives the counter clock pin, one edge per request
`timescale 1ns/1ps
`default_nettype none

module cudc_pin_model
(
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic req,
   output var  logic counter_clk,
   output var  logic ack
);

   // ***************************************************
   // Edge maker
   // ***************************************************
   // Pin stays put for at least 4 clocks, above the 2 the synchroniser needs
   logic [2:0] ph_r;

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         counter_clk <= 1'b0;
         ph_r        <= 3'h0;
         ack         <= 1'b0;
      end
      else if (!req)
      begin
         ph_r <= 3'h0;
         ack  <= 1'b0;
      end
      else if (!ack)
      begin
         ph_r <= ph_r + 3'h1;
         if (ph_r == 3'h0)
            counter_clk <= ~counter_clk;
         if (ph_r == 3'h3)
            ack <= 1'b1;
      end
   end

endmodule

`default_nettype wire

//--- test/tb_top.sv
// Testbench for the configurable up/down counter
`timescale 1ns/1ps
`default_nettype none

module tb_top;

   // ***************************************************
   // Signals and instances
   // ***************************************************
   logic        clock, rst, up, en, pre, clr, req, ack, pclk;
   logic [1:0]  errs;
   logic        psel, penable, pwrite, rdy_a, rdy_b, err_a, err_b;
   logic        oe_a, oe_b;
   logic [11:0] paddr;
   logic [31:0] pwdata, prd_a, prd_b, rdata, rdata_b;
   logic [7:0]  out_a;
   logic [3:0]  out_b;
   int          n_mismatch, compares;
   logic [7:0]  ea [6] = '{8'h00, 8'h00, 8'hff, 8'hff, 8'hfe, 8'hfe};
   logic [3:0]  eb [6] = '{4'h0, 4'h1, 4'h1, 4'h0, 4'h0, 4'hf};

   // Rising edge, sync loads, active-low preset and clear
   cudc_counter #(.POWER_UP_VALUE(255), .CLEAR_LOAD_VALUE(17),
      .PRESET_LOAD_VALUE(60), .PRESET_CLEAR_LEVEL(1'b0)) cudc_counter_i (
      .clock(clock), .rst(rst), .counter_clk(pclk), .count_up(up),
      .count_enable(en), .preset_in(~pre), .clear_in(~clr),
      .count_out(out_a), .count_oe(oe_a), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prd_a),
      .pready(rdy_a), .pslverr(err_a));

   // Falling edge, async loads, preset switched off, narrow
   cudc_counter #(.COUNTER_WIDTH(4),
      .CLOCK_EDGE_SELECT(cudc_pkg::CUDC_EDGE_FALL), .CLEAR_LOAD_VALUE(5),
      .PRESET_LOAD_VALUE(cudc_pkg::CUDC_IGNORE_VALUE),
      .LOAD_TIMING(cudc_pkg::CUDC_LOAD_ASYNC)) cudc_counter_fall_i (
      .clock(clock), .rst(rst), .counter_clk(pclk), .count_up(up),
      .count_enable(en), .preset_in(pre), .clear_in(clr),
      .count_out(out_b), .count_oe(oe_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prd_b),
      .pready(rdy_b), .pslverr(err_b));

   cudc_pin_model cudc_pin_model_i (.clock(clock), .rst(rst), .req(req),
      .counter_clk(pclk), .ack(ack));

   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // ***************************************************
   // Tasks
   // ***************************************************
   task end_sim;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task wt;
      repeat (6) @(posedge clock);
   endtask

   // One edge of the counter clock pin, then time for it to reach the output
   task tog;
      int n;
      n = 0;
      req <= 1'b1;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1)
      begin
         n_mismatch++;
         end_sim;
      end
      req <= 1'b0;
      wt;
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (rdy_a !== 1'b1 && n < 20);
      if (rdy_a !== 1'b1)
      begin
         n_mismatch++;
         end_sim;
      end
      rdata   = prd_a;
      rdata_b = prd_b;
      errs    = {err_a, err_b};
      chk(rdy_b, 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // ***************************************************
   // Sequence
   // ***************************************************
   initial
   begin
      {rst, up} = 2'b11;
      {en, pre, clr, req, psel, penable, pwrite} = 7'h00;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      n_mismatch = 0;
      compares = 0;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      wt;
      chk(oe_a, 1'b0);
      en <= 1'b1;
      wt;
      chk(oe_b, 1'b1);
      chk(out_a, 8'hff);
      chk(out_b, 4'h0);
      for (int i = 0; i < 6; i++)
      begin
         if (i == 2)
            up <= 1'b0;
         tog;
         chk(out_a, ea[i]);
         chk(out_b, eb[i]);
      end
      apb(1'b0, cudc_pkg::CUDC_COUNT_OFFSET, 32'h0);
      chk(rdata, 32'h0000_00fe);
      chk(rdata_b, 32'h0000_000f);
      chk(errs, 2'b00);
      // Frozen count must survive a selected edge
      apb(1'b1, cudc_pkg::CUDC_CTRL_OFFSET, 32'h1);
      tog;
      chk(out_a, 8'hfe);
      apb(1'b1, cudc_pkg::CUDC_CTRL_OFFSET, 32'h0);
      apb(1'b0, 12'h008, 32'h0);
      chk(errs, 2'b11);
      chk(rdata, 32'h0);
      // Clear and preset together: clear must win
      {clr, pre} <= 2'b11;
      wt;
      chk(out_b, 4'h5);
      chk(out_a, 8'hfe);
      tog;
      chk(out_a, 8'hfe);
      tog;
      chk(out_a, 8'h11);
      clr <= 1'b0;
      pre <= 1'b1;
      tog;
      chk(out_b, 4'h4);
      chk(out_a, 8'h11);
      tog;
      chk(out_a, 8'h3c);
      pre <= 1'b0;
      en <= 1'b0;
      wt;
      chk({oe_a, out_a}, 9'h000);
      end_sim;
   end

endmodule

`default_nettype wire
